// ---- tbf_axil.sv ----
/*
  AXI4-Lite slave front end: takes address and data in either order,
  presents one register write or read to the register bank.
  Assumes one write and one read at most outstanding.
*/
`timescale 1ns/1ps
module tbf_axil import tbf_pkg::*; (
  input logic clk,
  input logic srst,
  input logic [ADDR_W-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [ADDR_W-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  output logic wr_en,
  output logic [7:0] wr_idx,
  output logic [7:0] wr_data,
  input logic wr_ok,
  output logic [7:0] rd_idx,
  input logic [7:0] rd_data,
  input logic rd_ok
);
  logic aw_held, w_held, fire;
  logic next_aw_held, next_w_held, next_awready, next_wready;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid, next_arready;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  assign fire = aw_held && w_held && !bvalid;
  assign wr_en = fire && w_strb[0];
  assign wr_idx = aw_addr[9:2];
  assign wr_data = w_data[7:0];
  assign rd_idx = araddr[9:2];

  always_comb begin
    next_aw_held = fire ? 1'b0 : (aw_held || (awvalid && awready));
    next_w_held = fire ? 1'b0 : (w_held || (wvalid && wready));
    next_aw_addr = (awvalid && awready) ? awaddr : aw_addr;
    next_w_data = (wvalid && wready) ? wdata : w_data;
    next_w_strb = (wvalid && wready) ? wstrb : w_strb;
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
    next_bvalid = fire || (bvalid && !bready);
    next_bresp = fire ? (wr_ok ? RESP_OKAY : RESP_SLVERR) : bresp;
    next_rvalid = (arvalid && arready) || (rvalid && !rready);
    next_rdata = (arvalid && arready) ? {24'h000000, rd_data} : rdata;
    next_rresp = (arvalid && arready) ? (rd_ok ? RESP_OKAY : RESP_SLVERR) : rresp;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
      arready <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      arready <= next_arready;
    end
  end

  a_write_answer: assert property (@(posedge clk) disable iff (srst)
    fire |=> bvalid) else $error("write response missing");
  a_write_hold: assert property (@(posedge clk) disable iff (srst)
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped early");
endmodule : tbf_axil

// ---- tbf_delim.sv ----
/*
  Type B transmit delimiter sequencer: start-of-frame, end-of-frame and
  extra guard time, timed in system clocks per elementary time unit.
  Assumes start and stop are one-cycle pulses from the framer.
*/
`timescale 1ns/1ps
module tbf_delim import tbf_pkg::*; #(
  parameter int ETU = ETU_CYCLES
) (
  input logic clk,
  input logic srst,
  input tbf_cfg_t cfg,
  input logic start,
  input logic stop,
  output logic level,
  output logic busy,
  output logic done
);
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_SOF_LO = 6'h02, S_SOF_HI = 6'h04,
    S_BODY = 6'h08, S_EOF_LO = 6'h10, S_GUARD = 6'h20
  } tbf_tx_state_t;

  tbf_tx_state_t state, next_state;
  logic [15:0] cnt, next_cnt, guard_len;
  logic next_level, next_busy, next_done;

  // Width clear with adjust set is a host error; it falls to minimum.
  function automatic logic [15:0] lo_len(input tbf_cfg_t c);
    if (c.frame_delimiter_width && c.frame_delimiter_adjust)
      return 16'(DELIM_LO_MAX_ETU * ETU - ADJ_CYCLES);
    if (c.frame_delimiter_width)
      return 16'(DELIM_LO_MAX_ETU * ETU);
    return 16'(DELIM_LO_MIN_ETU * ETU);
  endfunction : lo_len

  function automatic logic [15:0] hi_len(input tbf_cfg_t c);
    if (c.frame_delimiter_width && c.frame_delimiter_adjust)
      return 16'(SOF_HI_MIN_ETU * ETU + ADJ_CYCLES);
    if (c.frame_delimiter_width)
      return 16'(SOF_HI_MAX_ETU * ETU);
    return 16'(SOF_HI_MIN_ETU * ETU);
  endfunction : hi_len

  assign guard_len = 16'(int'(cfg.tx_extra_guard_time) * ETU);

  always_comb begin
    next_state = state;
    next_cnt = cnt - 16'h0001;
    next_done = 1'b0;
    case (state)
      S_IDLE: begin
        next_cnt = cnt;
        if (start && cfg.tx_start_suppress) begin
          next_state = S_BODY;
        end else if (start) begin
          next_state = S_SOF_LO;
          next_cnt = lo_len(cfg);
        end
      end
      S_SOF_LO: if (cnt == 16'h0001) begin
        next_state = S_SOF_HI;
        next_cnt = hi_len(cfg);
      end
      S_SOF_HI: if (cnt == 16'h0001) next_state = S_BODY;
      S_BODY: begin
        next_cnt = guard_len;
        if (stop && !cfg.tx_end_suppress) begin
          next_state = S_EOF_LO;
          next_cnt = lo_len(cfg);
        end else if (stop && guard_len != 16'h0000) begin
          next_state = S_GUARD;
        end else if (stop) begin
          next_state = S_IDLE;
          next_done = 1'b1;
        end
      end
      S_EOF_LO: if (cnt == 16'h0001) begin
        next_cnt = guard_len;
        next_state = (guard_len != 16'h0000) ? S_GUARD : S_IDLE;
        next_done = (guard_len == 16'h0000);
      end
      S_GUARD: if (cnt == 16'h0001) begin
        next_state = S_IDLE;
        next_done = 1'b1;
      end
      default: next_state = S_IDLE;
    endcase
    next_level = !(next_state == S_SOF_LO || next_state == S_EOF_LO);
    next_busy = next_state != S_IDLE;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= S_IDLE;
      cnt <= 16'h0000;
      level <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      level <= next_level;
      busy <= next_busy;
      done <= next_done;
    end
  end

  logic [15:0] lo_run, hi_run, g_run;
  always_ff @(posedge clk) begin
    lo_run <= (srst || level) ? 16'h0000 : lo_run + 16'h0001;
    hi_run <= (srst || state != S_SOF_HI) ? 16'h0000 : hi_run + 16'h0001;
    g_run <= (srst || state != S_GUARD) ? 16'h0000 : g_run + 16'h0001;
  end

  sequence s_plain_start;
    state == S_IDLE && start && !cfg.tx_start_suppress;
  endsequence

  a_low_length: assert property (@(posedge clk) disable iff (srst)
    $rose(level) |-> lo_run == lo_len(cfg)) else $error("delimiter low length wrong");
  a_high_length: assert property (@(posedge clk) disable iff (srst)
    $fell(state == S_SOF_HI) |-> hi_run == hi_len(cfg)) else $error("sof high length wrong");
  a_sof_entry: assert property (@(posedge clk) disable iff (srst)
    s_plain_start |=> !level && state == S_SOF_LO) else $error("sof not started");
  a_sof_skip: assert property (@(posedge clk) disable iff (srst)
    state == S_IDLE && start && cfg.tx_start_suppress |=> level && state == S_BODY)
    else $error("suppressed sof sent");
  a_guard_len: assert property (@(posedge clk) disable iff (srst)
    done |-> g_run == guard_len) else $error("guard time wrong");
endmodule : tbf_delim

// ---- tbf_frame_regs.sv ----
/*
  Type B framing and checksum result register bank with receive
  delimiter filter, transmit delimiter timing and interrupt logic.
  Assumes the framer, checksum engine and bus master share MCLK.
*/
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
// Function
// - start frame required: ignore streams lacking it
// - start frame optional: strip it from FIFO
// - end frame required: missing end raises error
// - end frame optional: strip it, no error
// - width set, adjust clear: maximum delimiter length
// - both set: low 11 ETU-8, high 2 ETU+8
// - both clear: minimum delimiter length
// - guard field adds zero to three bits
// - speed register: coarse bits 7-5, fine 4-0
// - checksum high byte low address, low next
// - checksum bytes valid only with complete flag
module tbf_frame_regs import tbf_pkg::*; #(
  parameter int ETU = ETU_CYCLES
) (
  input logic MCLK,
  input logic SRST,
  input logic [ADDR_W-1:0] AWADDR,
  input logic AWVALID,
  output logic AWREADY,
  input logic [31:0] WDATA,
  input logic [3:0] WSTRB,
  input logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input logic BREADY,
  input logic [ADDR_W-1:0] ARADDR,
  input logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input logic RREADY,
  input tbf_rx_t RX,
  output logic FIFO_WR,
  output logic [7:0] FIFO_DATA,
  output logic RX_PROTOCOL_ERROR,
  input logic TX_FRAME_START,
  input logic TX_FRAME_END,
  output logic TX_LEVEL,
  output logic TX_BUSY,
  output logic TX_DONE,
  output logic [2:0] UART_COARSE_FACTOR,
  output logic [4:0] UART_FINE_FACTOR,
  input logic CRC_START,
  input logic CRC_DONE,
  input logic [15:0] CRC_VALUE,
  output logic IRQ
);
  logic wr_en, wr_ok, rd_ok;
  logic [7:0] wr_idx, wr_data, rd_idx, rd_data;
  logic [7:0] frame_cfg, next_frame_cfg;
  logic [7:0] uart_speed, next_uart_speed;
  logic adjust, next_adjust;
  tbf_cfg_t cfg;

  tbf_axil u_bus (
    .clk(MCLK),
    .srst(SRST),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_ok(wr_ok),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  function automatic logic mapped(input logic [7:0] idx);
    case (idx)
      IDX_FRAME_CFG, IDX_UART_SPEED, IDX_RSVD_20: return 1'b1;
      IDX_SUM_HIGH, IDX_SUM_LOW, IDX_AUX_CTRL: return 1'b1;
      IDX_STATUS, IDX_IRQ_STATUS, IDX_IRQ_ENABLE: return 1'b1;
      IDX_IRQ_CLEAR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : mapped

  assign wr_ok = mapped(wr_idx);
  assign rd_ok = mapped(rd_idx);

  // Configuration registers; the reserved bit 5 never stores a one.
  always_comb begin
    next_frame_cfg = frame_cfg;
    next_uart_speed = uart_speed;
    next_adjust = adjust;
    if (wr_en && wr_idx == IDX_FRAME_CFG)
      next_frame_cfg = wr_data & FRAME_CFG_WMASK;
    if (wr_en && wr_idx == IDX_UART_SPEED)
      next_uart_speed = wr_data;
    if (wr_en && wr_idx == IDX_AUX_CTRL)
      next_adjust = wr_data[BIT_ADJUST];
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      frame_cfg <= RST_FRAME_CFG;
      uart_speed <= RST_UART_SPEED;
      adjust <= 1'b0;
    end else begin
      frame_cfg <= next_frame_cfg;
      uart_speed <= next_uart_speed;
      adjust <= next_adjust;
    end
  end

  always_comb begin
    cfg.rx_start_frame_required = frame_cfg[7];
    cfg.rx_end_frame_required = frame_cfg[6];
    cfg.frame_delimiter_width = frame_cfg[4];
    cfg.frame_delimiter_adjust = adjust;
    cfg.tx_start_suppress = frame_cfg[3];
    cfg.tx_end_suppress = frame_cfg[2];
    cfg.tx_extra_guard_time = frame_cfg[1:0];
  end

  assign UART_COARSE_FACTOR = uart_speed[7:COARSE_LSB];
  assign UART_FINE_FACTOR = uart_speed[COARSE_LSB-1:0];

  tbf_delim #(.ETU(ETU)) u_delim (
    .clk(MCLK),
    .srst(SRST),
    .cfg(cfg),
    .start(TX_FRAME_START),
    .stop(TX_FRAME_END),
    .level(TX_LEVEL),
    .busy(TX_BUSY),
    .done(TX_DONE)
  );

  // Receive filter. Delimiters arrive as separate strobes and are never
  // forwarded, so the FIFO only ever sees payload bytes.
  logic in_frame, drop, eof_seen, frame_begin;
  logic next_in_frame, next_drop, next_eof_seen;
  logic next_fifo_wr, next_proto_err, next_ignored;
  logic [7:0] next_fifo_data;
  logic rx_ignored;

  assign frame_begin = !in_frame && (RX.sof || RX.byte_valid);

  always_comb begin
    next_in_frame = in_frame;
    next_drop = drop;
    next_eof_seen = eof_seen;
    next_fifo_wr = 1'b0;
    next_fifo_data = FIFO_DATA;
    next_proto_err = 1'b0;
    next_ignored = 1'b0;
    if (frame_begin) begin
      next_in_frame = 1'b1;
      next_drop = !RX.sof && cfg.rx_start_frame_required;
      next_eof_seen = 1'b0;
    end
    if (RX.byte_valid && !next_drop) begin
      next_fifo_wr = 1'b1;
      next_fifo_data = RX.data;
    end
    if (RX.eof && next_in_frame)
      next_eof_seen = 1'b1;
    if (RX.stream_end && next_in_frame) begin
      next_in_frame = 1'b0;
      next_ignored = next_drop;
      next_proto_err = !next_drop && !next_eof_seen
                       && cfg.rx_end_frame_required;
      next_drop = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      in_frame <= 1'b0;
      drop <= 1'b0;
      eof_seen <= 1'b0;
      FIFO_WR <= 1'b0;
      FIFO_DATA <= 8'h00;
      RX_PROTOCOL_ERROR <= 1'b0;
      rx_ignored <= 1'b0;
    end else begin
      in_frame <= next_in_frame;
      drop <= next_drop;
      eof_seen <= next_eof_seen;
      FIFO_WR <= next_fifo_wr;
      FIFO_DATA <= next_fifo_data;
      RX_PROTOCOL_ERROR <= next_proto_err;
      rx_ignored <= next_ignored;
    end
  end

  // Checksum result. A finish in the same cycle as a new start wins,
  // so a result is never hidden by a racing restart.
  logic [7:0] sum_high, sum_low, next_sum_high, next_sum_low;
  logic sum_ready, next_sum_ready;

  always_comb begin
    next_sum_high = sum_high;
    next_sum_low = sum_low;
    next_sum_ready = sum_ready && !CRC_START;
    if (CRC_DONE) begin
      next_sum_high = CRC_VALUE[15:8];
      next_sum_low = CRC_VALUE[7:0];
      next_sum_ready = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sum_high <= RST_SUM;
      sum_low <= RST_SUM;
      sum_ready <= 1'b0;
    end else begin
      sum_high <= next_sum_high;
      sum_low <= next_sum_low;
      sum_ready <= next_sum_ready;
    end
  end

  // Interrupts: a new event beats a clear written in the same cycle.
  logic [N_IRQ-1:0] irq_status, irq_enable, events;
  logic [N_IRQ-1:0] next_irq_status, next_irq_enable;
  logic next_irq;

  always_comb begin
    events = '0;
    events[IRQ_PROTO_ERR] = RX_PROTOCOL_ERROR;
    events[IRQ_RX_IGNORED] = rx_ignored;
    events[IRQ_TX_DONE] = TX_DONE;
    events[IRQ_SUM_DONE] = CRC_DONE;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    if (wr_en && wr_idx == IDX_IRQ_ENABLE)
      next_irq_enable = wr_data[N_IRQ-1:0];
    if (wr_en && wr_idx == IDX_IRQ_CLEAR)
      next_irq_status = irq_status & ~wr_data[N_IRQ-1:0];
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      irq_status <= '0;
      irq_enable <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      IRQ <= next_irq;
    end
  end

  // Read decode; unmapped and write-only words read as zero.
  always_comb begin
    rd_data = 8'h00;
    case (rd_idx)
      IDX_FRAME_CFG: rd_data = frame_cfg;
      IDX_UART_SPEED: rd_data = uart_speed;
      IDX_SUM_HIGH: rd_data = sum_high;
      IDX_SUM_LOW: rd_data = sum_low;
      IDX_AUX_CTRL: rd_data[BIT_ADJUST] = adjust;
      IDX_STATUS: begin
        rd_data[BIT_SUM_READY] = sum_ready;
        rd_data[BIT_TX_BUSY] = TX_BUSY;
        rd_data[BIT_RX_FRAME] = in_frame;
      end
      IDX_IRQ_STATUS: rd_data[N_IRQ-1:0] = irq_status;
      IDX_IRQ_ENABLE: rd_data[N_IRQ-1:0] = irq_enable;
      default: rd_data = 8'h00;
    endcase
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);

  sequence s_bare_start;
    !in_frame && RX.byte_valid && !RX.sof;
  endsequence

  a_rx_ignore: assert property (
    s_bare_start ##0 cfg.rx_start_frame_required && !RX.stream_end |=> drop && !FIFO_WR)
    else $error("stream without start frame not ignored");
  a_sof_strip: assert property (
    RX.sof && !RX.byte_valid |=> !FIFO_WR) else $error("start frame reached fifo");
  a_byte_pass: assert property (
    s_bare_start ##0 !cfg.rx_start_frame_required
    |=> FIFO_WR && FIFO_DATA == $past(RX.data)) else $error("byte lost");
  a_eof_error: assert property (
    in_frame && !drop && !eof_seen && !RX.eof && RX.stream_end
    && cfg.rx_end_frame_required |=> RX_PROTOCOL_ERROR) else $error("missing end not flagged");
  a_eof_optional: assert property (
    RX.stream_end && !cfg.rx_end_frame_required |=> !RX_PROTOCOL_ERROR)
    else $error("error without end required");
  a_sum_capture: assert property (
    CRC_DONE |=> sum_ready && {sum_high, sum_low} == $past(CRC_VALUE))
    else $error("checksum not captured");
  a_sum_invalid: assert property (
    CRC_START && !CRC_DONE |=> !sum_ready ##1 (sum_ready == $past(CRC_DONE) || sum_ready))
    else $error("complete flag not cleared");
  a_irq_level: assert property (IRQ == |(irq_status & irq_enable))
    else $error("interrupt line mismatch");
  a_speed_out: assert property (
    wr_en && wr_idx == IDX_UART_SPEED |=> UART_COARSE_FACTOR == $past(wr_data[7:5])
    && UART_FINE_FACTOR == $past(wr_data[4:0])) else $error("speed fields wrong");
endmodule : tbf_frame_regs

// ---- tbf_peer.sv ----
/*
  Far-side model: receive stream source, framer strobes, checksum engine.
  Assumes its tasks are called just after a rising MCLK edge.
*/
`timescale 1ns/1ps
module tbf_peer import tbf_pkg::*; (
  input wire logic clk,
  output tbf_rx_t rx,
  output logic tx_start,
  output logic tx_end,
  output logic crc_start,
  output logic crc_done,
  output logic [15:0] crc_value
);
  initial begin
    rx = '0;
    tx_start = 1'b0;
    tx_end = 1'b0;
    crc_start = 1'b0;
    crc_done = 1'b0;
    crc_value = 16'hC3A5;
  end

  task automatic strobe(input logic [11:0] s);
    rx <= s;
    @(posedge clk);
    rx <= '0;
    @(posedge clk);
  endtask : strobe

  task automatic frame(input logic s, input logic e, input logic [7:0] d);
    if (s) strobe(12'h800);
    strobe({2'b01, d, 2'b00});
    if (e) strobe(12'h002);
    strobe(12'h001);
  endtask : frame

  // The value bus is inverted in the cycle after each call's pulse, so a late sample shows.
  task automatic crc(input logic st, input logic [15:0] v);
    crc_start <= st;
    crc_done <= ~st;
    crc_value <= v;
    @(posedge clk);
    crc_start <= 1'b0;
    crc_done <= 1'b0;
    crc_value <= ~v;
    @(posedge clk);
  endtask : crc

  task automatic tx(input logic e);
    tx_start <= ~e;
    tx_end <= e;
    @(posedge clk);
    tx_start <= 1'b0;
    tx_end <= 1'b0;
  endtask : tx
endmodule : tbf_peer

// ---- tbf_pkg.sv ----
/*
  Shared constants and carriers of the type B framing register bank.
  Assumes a 20 MHz system clock and registers reached over AXI4-Lite.
*/
package tbf_pkg;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_FRAME_CFG = 8'h1E;
  localparam logic [7:0] IDX_UART_SPEED = 8'h1F;
  localparam logic [7:0] IDX_RSVD_20 = 8'h20;
  localparam logic [7:0] IDX_SUM_HIGH = 8'h21;
  localparam logic [7:0] IDX_SUM_LOW = 8'h22;
  localparam logic [7:0] IDX_AUX_CTRL = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h32;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h33;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h34;
  localparam logic [7:0] RST_FRAME_CFG = 8'h00;
  localparam logic [7:0] RST_UART_SPEED = 8'hEB;
  localparam logic [7:0] RST_SUM = 8'hFF;
  localparam logic [7:0] FRAME_CFG_WMASK = 8'hDF;
  localparam int COARSE_LSB = 5;
  localparam int BIT_ADJUST = 0;
  localparam int BIT_SUM_READY = 0;
  localparam int BIT_TX_BUSY = 1;
  localparam int BIT_RX_FRAME = 2;
  localparam int N_IRQ = 4;
  localparam int IRQ_PROTO_ERR = 0;
  localparam int IRQ_RX_IGNORED = 1;
  localparam int IRQ_TX_DONE = 2;
  localparam int IRQ_SUM_DONE = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ETU_NS = 9440;
  localparam int ETU_CYCLES = ETU_NS / CLK_PERIOD_NS;
  localparam int ADJ_CYCLES = 8;
  localparam int DELIM_LO_MAX_ETU = 11;
  localparam int DELIM_LO_MIN_ETU = 10;
  localparam int SOF_HI_MAX_ETU = 3;
  localparam int SOF_HI_MIN_ETU = 2;

  typedef struct packed {
    logic rx_start_frame_required;
    logic rx_end_frame_required;
    logic frame_delimiter_width;
    logic frame_delimiter_adjust;
    logic tx_start_suppress;
    logic tx_end_suppress;
    logic [1:0] tx_extra_guard_time;
  } tbf_cfg_t;

  typedef struct packed {
    logic sof;
    logic byte_valid;
    logic [7:0] data;
    logic eof;
    logic stream_end;
  } tbf_rx_t;
endpackage : tbf_pkg

// ---- testbench.sv ----
/*
  Self-checking bench for the framing register bank over AXI4-Lite.
  Assumes a short ETU of 4 cycles so delimiter phases stay brief.
*/
`timescale 1ns/1ps
module testbench import tbf_pkg::*;;
  localparam int E = 4;
  logic MCLK, SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FIFO_WR, RX_PROTOCOL_ERROR;
  logic TX_LEVEL, TX_BUSY, TX_DONE, IRQ, TX_FRAME_START, TX_FRAME_END;
  logic CRC_START, CRC_DONE;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, r;
  logic [7:0] FIFO_DATA;
  logic [2:0] UART_COARSE_FACTOR;
  logic [4:0] UART_FINE_FACTOR;
  logic [15:0] CRC_VALUE;
  tbf_rx_t RX;
  int n_fail, samples_checked, n_fifo, n_err, ls, le, th, base, i, k;
  logic [7:0] cfgs [7] = '{8'h10, 8'h10, 8'h00, 8'h0B, 8'h04, 8'h01, 8'h02};

  tbf_frame_regs #(.ETU(E)) i_tbf_frame_regs (.*);
  tbf_peer i_tbf_peer (.clk(MCLK), .rx(RX), .tx_start(TX_FRAME_START),
    .tx_end(TX_FRAME_END), .crc_start(CRC_START), .crc_done(CRC_DONE),
    .crc_value(CRC_VALUE));

  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    if (FIFO_WR === 1'b1) n_fifo++;
    if (RX_PROTOCOL_ERROR === 1'b1) n_err++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] rs);
    AWADDR <= {idx, 2'b00};
    AWVALID <= 1'b1;
    WDATA <= {24'h0, d};
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    rs = 2'h3;
    for (int n = 0; n < 50; n++) begin
      @(posedge MCLK);
      if (AWVALID && AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WVALID && WREADY === 1'b1) WVALID <= 1'b0;
      if (BVALID === 1'b1) begin
        rs = BRESP;
        BREADY <= 1'b0;
        break;
      end
    end
    @(posedge MCLK);
  endtask : wr

  task automatic w(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] rs;
    wr(idx, d, rs);
    chk(rs, RESP_OKAY);
  endtask : w

  task automatic ck(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] rs;
    ARADDR <= {idx, 2'b00};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    d = 32'hFFFFFFFF;
    rs = 2'h3;
    for (int n = 0; n < 50; n++) begin
      @(posedge MCLK);
      if (ARVALID && ARREADY === 1'b1) ARVALID <= 1'b0;
      if (RVALID === 1'b1) begin
        d = RDATA;
        rs = RRESP;
        RREADY <= 1'b0;
        break;
      end
    end
    @(posedge MCLK);
    chk(d, {24'h000000, exp});
    chk(rs, RESP_OKAY);
  endtask : ck

  initial begin
    // The whole run is about a thousand cycles; this bound only cuts a hang.
    #(30000 * 50);
    n_fail++;
    end_sim();
  end

  initial begin
    {SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h20;
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    WSTRB = 4'hF;
    repeat (6) @(posedge MCLK);
    SRST <= 1'b0;
    @(posedge MCLK);
    ck(IDX_FRAME_CFG, 8'h00);
    ck(IDX_UART_SPEED, 8'hEB);
    ck(IDX_RSVD_20, 8'h00);
    ck(IDX_SUM_HIGH, 8'hFF);
    ck(IDX_SUM_LOW, 8'hFF);
    chk({UART_COARSE_FACTOR, UART_FINE_FACTOR}, 8'hEB);
    w(IDX_FRAME_CFG, 8'hFF);
    ck(IDX_FRAME_CFG, 8'hDF);
    w(IDX_UART_SPEED, 8'hA5);
    chk({UART_COARSE_FACTOR, UART_FINE_FACTOR}, {3'h5, 5'h05});
    w(IDX_SUM_HIGH, 8'h00);
    ck(IDX_SUM_HIGH, 8'hFF);
    wr(8'h2F, 8'h00, r);
    chk(r, RESP_SLVERR);
    i_tbf_peer.crc(1'b0, 16'h1234);
    ck(IDX_STATUS, 8'h01);
    ck(IDX_SUM_HIGH, 8'h12);
    ck(IDX_SUM_LOW, 8'h34);
    i_tbf_peer.crc(1'b1, 16'h0000);
    ck(IDX_STATUS, 8'h00);
    w(IDX_IRQ_ENABLE, 8'h0F);
    ck(IDX_IRQ_STATUS, 8'h08);
    chk(IRQ, 1'b1);
    w(IDX_IRQ_CLEAR, 8'h0F);
    ck(IDX_IRQ_STATUS, 8'h00);
    chk(IRQ, 1'b0);
    w(IDX_FRAME_CFG, 8'h80);
    i_tbf_peer.frame(1'b0, 1'b1, 8'h3C);
    repeat (3) @(posedge MCLK);
    chk(n_fifo, 0);
    ck(IDX_IRQ_STATUS, 8'h02);
    w(IDX_IRQ_CLEAR, 8'h0F);
    w(IDX_FRAME_CFG, 8'h00);
    i_tbf_peer.frame(1'b1, 1'b1, 8'h5A);
    repeat (3) @(posedge MCLK);
    chk({n_fifo[7:0], FIFO_DATA, n_err[7:0]}, 24'h015A00);
    w(IDX_FRAME_CFG, 8'h40);
    i_tbf_peer.frame(1'b0, 1'b0, 8'h66);
    i_tbf_peer.frame(1'b0, 1'b1, 8'h67);
    repeat (3) @(posedge MCLK);
    chk({n_fifo[7:0], n_err[7:0]}, 16'h0301);
    ck(IDX_IRQ_STATUS, 8'h01);
    for (i = 0; i < 7; i++) begin
      w(IDX_AUX_CTRL, 8'h00);
      w(IDX_FRAME_CFG, cfgs[i]);
      if (i == 0) w(IDX_AUX_CTRL, 8'h01);
      {ls, le, th} = '0;
      i_tbf_peer.tx(1'b0);
      for (k = 0; k < 60; k++) begin
        @(posedge MCLK);
        if (TX_LEVEL === 1'b0) ls++;
      end
      ck(IDX_STATUS, 8'h02);
      i_tbf_peer.tx(1'b1);
      for (k = 0; k < 300 && TX_DONE !== 1'b1; k++) begin
        @(posedge MCLK);
        if (TX_LEVEL === 1'b0) le++;
        else th++;
      end
      k = cfgs[i][4] ? (i == 0 ? 11 * E - 8 : 11 * E) : 10 * E;
      if (i == 0) base = th;
      chk(ls, cfgs[i][3] ? 0 : k);
      chk(le, cfgs[i][2] ? 0 : k);
      chk(th - base, cfgs[i][1:0] * E);
    end
    end_sim();
  end
endmodule : testbench
